// *** design/mpsb_pkg.sv ***
// Package: constants and types for the port burst counter block
package mpsb_pkg;
    localparam int ADDR_W          = 16;
    localparam int BYTE_W          = 9;
    localparam int DATA_W          = 2 * BYTE_W;
    localparam int LO_LSB          = 0;
    localparam int HI_LSB          = BYTE_W;
    localparam int DEPTH           = 65536;
    localparam logic [15:0] CNT_RST_VAL  = 16'h0000;
    localparam logic [15:0] MASK_RST_VAL = 16'hFFFF;
    localparam logic [31:0] VER_VAL      = 32'h0000_0001; // Arbitrary value
    localparam int RDBK_LAT        = 2;
    localparam logic [11:0] OFF_CTRL  = 12'h000;
    localparam logic [11:0] OFF_CNT   = 12'h004;
    localparam logic [11:0] OFF_MASK  = 12'h008;
    localparam logic [11:0] OFF_STAT  = 12'h00C;
    localparam logic [11:0] OFF_WDATA = 12'h010;
    localparam logic [11:0] OFF_RDATA = 12'h014;
    localparam logic [11:0] OFF_VER   = 12'h018;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MPSB_OP_NONE,
        MPSB_OP_CLR,
        MPSB_OP_MASK,
        MPSB_OP_LOAD
    } mpsb_op_t;
endpackage

// *** design/mpsb_ctr_if.sv ***
// Interface: burst counter core control and state
`timescale 1ns/1ps
interface mpsb_ctr_if;
    logic                          clear_n;
    logic                          mask_load_n;
    logic                          load_n;
    logic                          advance_n;
    logic [mpsb_pkg::ADDR_W-1:0]   addr_in;
    logic [mpsb_pkg::ADDR_W-1:0]   count;
    logic [mpsb_pkg::ADDR_W-1:0]   mask;
    logic                          wrap_n;

    modport core (
        input  clear_n, mask_load_n, load_n, advance_n, addr_in,
        output count, mask, wrap_n
    );
    modport user (
        output clear_n, mask_load_n, load_n, advance_n, addr_in,
        input  count, mask, wrap_n
    );
endinterface

// *** design/mpsb_ctr.sv ***
// Burst address counter with wrap mask
`timescale 1ns/1ps
module mpsb_ctr (
    input  wire logic     aclk,
    input  wire logic     aclken,
    input  wire logic     master_reset_n,
    mpsb_ctr_if.core      ctr
);
    typedef struct packed {
        logic [mpsb_pkg::ADDR_W-1:0] count;
        logic [mpsb_pkg::ADDR_W-1:0] mask;
        logic                        wrap_n;
    } mpsb_ctr_st_t;

    mpsb_ctr_st_t st_q;
    mpsb_ctr_st_t st_d;
    logic [mpsb_pkg::ADDR_W-1:0] inc;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d        = st_q;
        st_d.wrap_n = 1'b1;
        inc         = ((st_q.count & st_q.mask) + 16'h0001) & st_q.mask;
        if (!ctr.clear_n) begin
            st_d.count = mpsb_pkg::CNT_RST_VAL; // R9 R10
        end else if (!ctr.mask_load_n) begin
            st_d.mask = ctr.addr_in; // R11 R12
        end else if (!ctr.load_n) begin
            st_d.count = ctr.addr_in; // R13
        end else if (!ctr.advance_n) begin
            st_d.count = (st_q.count & ~st_q.mask) | inc; // R14 R20
            if (inc == 16'h0000) begin
                st_d.wrap_n = 1'b0; // R18
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            st_q.count  <= mpsb_pkg::CNT_RST_VAL; // R7
            st_q.mask   <= mpsb_pkg::MASK_RST_VAL;
            st_q.wrap_n <= 1'b1;
        end else if (aclken) begin
            st_q <= st_d; // R15
        end
    end

    assign ctr.count  = st_q.count;
    assign ctr.mask   = st_q.mask;
    assign ctr.wrap_n = st_q.wrap_n;
endmodule

// *** design/mpsb_port.sv ***
// Contract
// R1: lower data byte accessed only while lower byte select is low; with sw_ctrl set the code enables both bytes whatever the selects
// R2: lower byte driven on read only with byte select and output enable low; with sw_ctrl set the code drives both lanes whatever the selects
// R3: upper byte select gates the upper byte the same way
// R4: port selected only with low enable low and high enable high
// R5: data drivers on during reads only while output enable low, unsampled
// R6: read/write low writes the array, high reads it; with sw_ctrl set the code writes the array from sw_wr instead
// R7: shared master reset acts asynchronously and resets everything; the memory array and mem_rd_q are not reset
// R8: system must apply master reset after power-up
// R9: counter clear low sets the burst counter to zero
// R10: counter clear ranks below master reset, above other counter operations
// R11: mask load low captures address lines into the mask register
// R12: mask load beats counter load in the same cycle
// R13: counter load low loads the counter from the address pins
// R14: advance low increments the counter on every rising clock edge
// R15: port works with free-running or gated clock
// R16: counter readback drives counter onto address lines; host holds load high
// R17: mask readback drives mask onto address lines; counter readback wins
// R18: wrap flag low exactly one cycle when counter wraps to zero
// R19: 16-bit address bus, 18-bit data bus of two 9-bit bytes
// R20: inputs sampled at rising edge; mask limits changing counter bits
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module mpsb_port #(
    parameter int ADDR_W = mpsb_pkg::ADDR_W,
    parameter int BYTE_W = mpsb_pkg::BYTE_W
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 aclken,
    input  wire logic                 master_reset_n,
    input  wire logic [ADDR_W-1:0]    addr_i,
    output logic      [ADDR_W-1:0]    addr_o,
    output logic                      addr_oe_n,
    input  wire logic [2*BYTE_W-1:0]  data_i,
    output logic      [2*BYTE_W-1:0]  data_o,
    output logic      [1:0]           data_oe_n,
    input  wire logic                 lower_byte_select_n,
    input  wire logic                 upper_byte_select_n,
    input  wire logic                 chip_enable_active_low,
    input  wire logic                 chip_enable_active_high,
    input  wire logic                 output_enable_n,
    input  wire logic                 read_write_n,
    input  wire logic                 burst_counter_clear_n,
    input  wire logic                 wrap_mask_load_n,
    input  wire logic                 burst_counter_load_n,
    input  wire logic                 burst_counter_advance_n,
    input  wire logic                 counter_readback_n,
    input  wire logic                 wrap_mask_readback_n,
    output logic                      wrap_flag_n,
    input  wire logic [31:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic      [1:0]           s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [31:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic      [31:0]          s_axi_rdata,
    output logic      [1:0]           s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready
);
    localparam int DW = 2 * BYTE_W; // R19

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic            sel;
        logic            rd;
        logic [1:0]      rd_lane;
        logic [DW-1:0]   rdata;
        logic [1:0]      rdbk;
        logic            rdbk_cnt;
        logic [ADDR_W-1:0] addr_o;
        logic            addr_oe_n;
        logic            wrap_n;
        logic            aw_got;
        logic            w_got;
        logic [11:0]     awaddr;
        logic [31:0]     wdata;
        logic [3:0]      wstrb;
        logic            awready;
        logic            wready;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            arready;
        logic            rvalid;
        logic [31:0]     rdata_bus;
        logic [1:0]      rresp;
        logic            sw_ctrl;
        logic [DW-1:0]   sw_wdata;
        logic            sw_wr;
        logic            sw_rd;
    } mpsb_port_st_t;

    mpsb_port_st_t st_q;
    mpsb_port_st_t st_d;

    logic [DW-1:0]     mem_rd_q;
    logic [ADDR_W-1:0] mem_addr;
    logic [1:0]        byte_en;
    logic              sel_now;
    logic              do_wr;
    logic [DW-1:0]     wr_val;

    mpsb_ctr_if ctr ();

    mpsb_ctr u_ctr (
        .aclk           (aclk),
        .aclken         (aclken),
        .master_reset_n (master_reset_n),
        .ctr            (ctr)
    );

    assign ctr.clear_n     = burst_counter_clear_n;
    assign ctr.mask_load_n = wrap_mask_load_n;
    assign ctr.load_n      = burst_counter_load_n;
    assign ctr.advance_n   = burst_counter_advance_n;
    assign ctr.addr_in     = addr_i;

    // ------------------------------------------------------------
    // Array access
    // ------------------------------------------------------------
    assign sel_now = !chip_enable_active_low && chip_enable_active_high; // R4
    assign mem_addr = (!burst_counter_advance_n) ? ctr.count : addr_i;
    assign byte_en  = st_q.sw_ctrl ? 2'h3
                    : {!upper_byte_select_n, !lower_byte_select_n}; // R1 R3
    assign do_wr = st_q.sw_ctrl ? st_q.sw_wr
                 : (sel_now && !read_write_n); // R6
    assign wr_val = st_q.sw_ctrl ? st_q.sw_wdata : data_i;

    genvar b;
    generate
        for (b = 0; b < 2; b++) begin : g_lane
            logic [BYTE_W-1:0] mem [mpsb_pkg::DEPTH];

            always_ff @(posedge aclk) begin
                if (aclken) begin
                    if (do_wr && byte_en[b]) begin
                        mem[mem_addr] <= wr_val[b*BYTE_W +: BYTE_W]; // R1 R3
                    end
                    mem_rd_q[b*BYTE_W +: BYTE_W] <= mem[mem_addr];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d         = st_q;
        st_d.rdata   = mem_rd_q;
        st_d.sel     = sel_now;
        st_d.rd      = sel_now && read_write_n; // R6
        st_d.rd_lane = byte_en;
        st_d.wrap_n  = ctr.wrap_n; // R18
        st_d.sw_wr   = 1'b0;
        st_d.sw_rd   = 1'b0;
        if (!counter_readback_n) begin
            st_d.rdbk     = 2'h1;
            st_d.rdbk_cnt = 1'b1; // R16 R17
        end else if (!wrap_mask_readback_n) begin
            st_d.rdbk     = 2'h1;
            st_d.rdbk_cnt = 1'b0; // R17
        end else begin
            st_d.rdbk = 2'h0;
        end
        if (st_q.rdbk != 2'h0 && st_q.rdbk < 2'(mpsb_pkg::RDBK_LAT)) begin
            st_d.rdbk = st_q.rdbk + 2'h1;
        end
        st_d.addr_oe_n = !(st_q.rdbk != 2'h0);
        st_d.addr_o = st_q.rdbk_cnt ? ctr.count : ctr.mask; // R16 R17
        if (st_q.sw_rd) begin
            st_d.wdata[DW-1:0] = mem_rd_q;
        end

        // AXI4-Lite write path
        if (s_axi_awvalid && st_q.awready) begin
            st_d.aw_got  = 1'b1;
            st_d.awready = 1'b0;
            st_d.awaddr  = s_axi_awaddr[11:0];
        end
        if (s_axi_wvalid && st_q.wready) begin
            st_d.w_got  = 1'b1;
            st_d.wready = 1'b0;
            st_d.wdata  = s_axi_wdata;
            st_d.wstrb  = s_axi_wstrb;
        end
        if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
            st_d.bvalid = 1'b1;
            st_d.bresp  = mpsb_pkg::RESP_OKAY;
            case (st_q.awaddr)
                mpsb_pkg::OFF_CTRL: begin
                    if (st_q.wstrb[0]) begin
                        st_d.sw_ctrl = st_q.wdata[0];
                        st_d.sw_wr   = st_q.wdata[1];
                        st_d.sw_rd   = st_q.wdata[2];
                    end
                end
                mpsb_pkg::OFF_WDATA: st_d.sw_wdata = st_q.wdata[DW-1:0];
                default: st_d.bresp = mpsb_pkg::RESP_SLVERR;
            endcase
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid  = 1'b0;
            st_d.aw_got  = 1'b0;
            st_d.w_got   = 1'b0;
            st_d.awready = 1'b1;
            st_d.wready  = 1'b1;
        end

        // AXI4-Lite read path
        if (s_axi_arvalid && st_q.arready) begin
            st_d.arready = 1'b0;
            st_d.rvalid  = 1'b1;
            st_d.rresp   = mpsb_pkg::RESP_OKAY;
            case (s_axi_araddr[11:0])
                mpsb_pkg::OFF_CTRL: begin
                    st_d.rdata_bus = {31'h0, st_q.sw_ctrl};
                end
                mpsb_pkg::OFF_CNT: begin
                    st_d.rdata_bus = {16'h0, ctr.count};
                end
                mpsb_pkg::OFF_MASK: begin
                    st_d.rdata_bus = {16'h0, ctr.mask};
                end
                mpsb_pkg::OFF_STAT: begin
                    st_d.rdata_bus = {29'h0, st_q.wrap_n, st_q.rd, st_q.sel};
                end
                mpsb_pkg::OFF_WDATA: begin
                    st_d.rdata_bus = {14'h0, st_q.sw_wdata};
                end
                mpsb_pkg::OFF_RDATA: begin
                    st_d.rdata_bus = {14'h0, mem_rd_q};
                end
                mpsb_pkg::OFF_VER: begin
                    st_d.rdata_bus = mpsb_pkg::VER_VAL;
                end
                default: begin
                    st_d.rdata_bus = 32'h0000_0000;
                    st_d.rresp     = mpsb_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid  = 1'b0;
            st_d.arready = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            st_q           <= '0; // R7
            st_q.addr_oe_n <= 1'b1;
            st_q.wrap_n    <= 1'b1;
            st_q.awready   <= 1'b1;
            st_q.wready    <= 1'b1;
            st_q.arready   <= 1'b1;
        end else if (!aresetn) begin
            st_q           <= '0;
            st_q.addr_oe_n <= 1'b1;
            st_q.wrap_n    <= 1'b1;
            st_q.awready   <= 1'b1;
            st_q.wready    <= 1'b1;
            st_q.arready   <= 1'b1;
        end else if (aclken) begin
            st_q <= st_d; // R15 R20
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb begin
        data_o = st_q.rdata;
        for (int i = 0; i < 2; i++) begin
            // Readback three-states the data lines
            data_oe_n[i] = !(st_q.rd && st_q.rd_lane[i] && !output_enable_n
                             && st_q.rdbk == 2'h0); // R2 R5
        end
    end

    assign addr_o        = st_q.addr_o;
    assign addr_oe_n     = st_q.addr_oe_n;
    assign wrap_flag_n   = st_q.wrap_n;
    assign s_axi_awready = st_q.awready;
    assign s_axi_wready  = st_q.wready;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rdata   = st_q.rdata_bus;
    assign s_axi_rresp   = st_q.rresp;
endmodule

// *** tb/mpsb_port_chk.sv ***
// Checker: pin and counter assertions for the port block
`timescale 1ns/1ps
module mpsb_port_chk #(
    parameter int ADDR_W = 16
) (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              aclken,
    input wire logic              master_reset_n,
    input wire logic [ADDR_W-1:0] addr_o,
    input wire logic              addr_oe_n,
    input wire logic [1:0]        data_oe_n,
    input wire logic              lower_byte_select_n,
    input wire logic              upper_byte_select_n,
    input wire logic              chip_enable_active_low,
    input wire logic              chip_enable_active_high,
    input wire logic              output_enable_n,
    input wire logic              read_write_n,
    input wire logic              burst_counter_clear_n,
    input wire logic              burst_counter_load_n,
    input wire logic              burst_counter_advance_n,
    input wire logic              counter_readback_n,
    input wire logic              wrap_mask_readback_n,
    input wire logic              wrap_flag_n
);
    // ----
    // Helpers
    // ----
    wire sel = !chip_enable_active_low && chip_enable_active_high;
    wire rd_lo = sel && read_write_n && !lower_byte_select_n;
    wire rd_hi = sel && read_write_n && !upper_byte_select_n;
    wire rb = !counter_readback_n || !wrap_mask_readback_n;
    wire quiet = burst_counter_clear_n && burst_counter_load_n
        && burst_counter_advance_n;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !master_reset_n);

    // ----
    // Assertions
    // ----
    oe_off_a: assert property (output_enable_n |-> data_oe_n == 2'h3)
        else $error("lane driven with output enable high");
    lo_lane_a: assert property (!data_oe_n[0] |-> !output_enable_n &&
        ($past(rd_lo) || $past(rd_lo, 2) || $past(rd_lo, 3)))
        else $error("lower lane driven without lower read");
    hi_lane_a: assert property (!data_oe_n[1] |-> !output_enable_n &&
        ($past(rd_hi) || $past(rd_hi, 2) || $past(rd_hi, 3)))
        else $error("upper lane driven without upper read");
    rdbk_drv_a: assert property (!addr_oe_n |->
        $past(rb) || $past(rb, 2) || $past(rb, 3))
        else $error("address driven without readback");
    clr_rdbk_a: assert property (!burst_counter_clear_n ##1
        (quiet && !counter_readback_n)[*4] |-> addr_o == '0)
        else $error("cleared counter reads back nonzero");
    wrap_once_a: assert property ($fell(wrap_flag_n) |=> wrap_flag_n)
        else $error("wrap flag low longer than one cycle");
    wrap_cause_a: assert property (!wrap_flag_n |->
        $past(!burst_counter_advance_n && aclken, 2))
        else $error("wrap flag without advance");
    gate_hold_a: assert property (!aclken |=>
        $stable(addr_o) && $stable(wrap_flag_n))
        else $error("state moved with clock enable low");
endmodule

bind mpsb_port mpsb_port_chk #(.ADDR_W(ADDR_W)) i_mpsb_port_chk (
    .aclk, .aresetn, .aclken, .master_reset_n, .addr_o, .addr_oe_n,
    .data_oe_n, .lower_byte_select_n, .upper_byte_select_n,
    .chip_enable_active_low, .chip_enable_active_high, .output_enable_n,
    .read_write_n, .burst_counter_clear_n, .burst_counter_load_n,
    .burst_counter_advance_n, .counter_readback_n, .wrap_mask_readback_n,
    .wrap_flag_n);

// *** tb/mpsb_host_model.sv ***
// Host side model: resolves the shared address and data pins
`timescale 1ns/1ps
module mpsb_host_model (
    input  wire logic        aclk,
    input  wire logic        read_write_n,
    input  wire logic        counter_readback_n,
    input  wire logic        wrap_mask_readback_n,
    input  wire logic [15:0] host_addr,
    input  wire logic [17:0] host_data,
    input  wire logic [15:0] addr_o,
    input  wire logic        addr_oe_n,
    input  wire logic [17:0] data_o,
    input  wire logic [1:0]  data_oe_n,
    output logic      [15:0] addr_w,
    output logic      [17:0] data_w
);
    logic [15:0] a_last_q;
    logic [17:0] d_last_q;

    // Released lines show a changing pattern
    always_comb begin
        if (!addr_oe_n) begin
            addr_w = addr_o;
        end else if (counter_readback_n && wrap_mask_readback_n) begin
            addr_w = host_addr;
        end else begin
            addr_w = ~a_last_q;
        end
        for (int i = 0; i < 2; i++) begin
            if (!data_oe_n[i]) begin
                data_w[i*9 +: 9] = data_o[i*9 +: 9];
            end else if (!read_write_n) begin
                data_w[i*9 +: 9] = host_data[i*9 +: 9];
            end else begin
                data_w[i*9 +: 9] = ~d_last_q[i*9 +: 9];
            end
        end
    end

    always_ff @(posedge aclk) begin
        a_last_q <= addr_w;
        d_last_q <= data_w;
    end
endmodule

// *** tb/multiport_sram_port_burst_counter_tb.sv ***
// Testbench: pin, counter and bus tests for the port block
`timescale 1ns/1ps
module multiport_sram_port_burst_counter_tb;
    localparam logic [10:0] SEL = 11'h400;
    localparam logic [10:0] LB  = 11'h200;
    localparam logic [10:0] UB  = 11'h100;
    localparam logic [10:0] OE  = 11'h080;
    localparam logic [10:0] WR  = 11'h040;
    localparam logic [10:0] CLR = 11'h020;
    localparam logic [10:0] MK  = 11'h010;
    localparam logic [10:0] LD  = 11'h008;
    localparam logic [10:0] ADV = 11'h004;
    localparam logic [10:0] CRD = 11'h002;
    localparam logic [10:0] MRD = 11'h001;
    logic        aclk, aresetn, aclken, master_reset_n, addr_oe_n;
    logic        lower_byte_select_n, upper_byte_select_n, output_enable_n;
    logic        chip_enable_active_low, chip_enable_active_high;
    logic        read_write_n, burst_counter_clear_n, wrap_mask_load_n;
    logic        burst_counter_load_n, burst_counter_advance_n, wrap_flag_n;
    logic        counter_readback_n, wrap_mask_readback_n;
    logic [15:0] host_addr, addr_w, addr_o;
    logic [17:0] host_data, data_w, data_o;
    logic [1:0]  data_oe_n, s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          bad_count, samples_checked, cycles, wrap_lows, w0;

    mpsb_port i_mpsb_port (
        .aclk, .aresetn, .aclken, .master_reset_n, .addr_i(addr_w), .addr_o,
        .addr_oe_n, .data_i(data_w), .data_o, .data_oe_n,
        .lower_byte_select_n, .upper_byte_select_n, .chip_enable_active_low,
        .chip_enable_active_high, .output_enable_n, .read_write_n,
        .burst_counter_clear_n, .wrap_mask_load_n, .burst_counter_load_n,
        .burst_counter_advance_n, .counter_readback_n, .wrap_mask_readback_n,
        .wrap_flag_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    mpsb_host_model i_mpsb_host_model (
        .aclk, .read_write_n, .counter_readback_n, .wrap_mask_readback_n,
        .host_addr, .host_data, .addr_o, .addr_oe_n, .data_o, .data_oe_n,
        .addr_w, .data_w);

    always #2.5 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles++;
        if (wrap_flag_n === 1'b0) wrap_lows++;
        if (cycles == 3000) begin
            bad_count++;
            wrap_up;
        end
    end

    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic op(input logic [10:0] c, input logic [15:0] a,
                      input logic [17:0] d, input int n);
        {chip_enable_active_low, lower_byte_select_n, upper_byte_select_n,
         output_enable_n, read_write_n, burst_counter_clear_n,
         wrap_mask_load_n, burst_counter_load_n, burst_counter_advance_n,
         counter_readback_n, wrap_mask_readback_n} <= ~c;
        chip_enable_active_high <= c[10];
        host_addr <= a;
        host_data <= d;
        repeat (n) @(posedge aclk);
    endtask
    task automatic rdbk(input logic [10:0] c, input logic [15:0] e);
        op(c, '0, '0, 5);
        chk(addr_o, e);
        op('0, '0, '0, 3);
    endtask
    task automatic axw(input logic [31:0] a, d, input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, r);
        @(posedge aclk);
    endtask
    task automatic axr(input logic [31:0] a, e, input logic [1:0] r);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rresp, r);
        if (r == mpsb_pkg::RESP_OKAY) chk(s_axi_rdata, e);
        @(posedge aclk);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----
    // Sequence
    // ----
    initial begin
        {aclk, aresetn, master_reset_n, aclken} = 4'h1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        op('0, '0, '0, 8);
        {aresetn, master_reset_n} <= 2'h3;
        op('0, '0, '0, 1);
        rdbk(CRD, 16'h0000);
        rdbk(MRD, 16'hFFFF);
        $display("reset test done");
        op(LD, 16'h0005, '0, 1);
        aclken <= 1'b0;
        op(ADV, '0, '0, 3);
        aclken <= 1'b1;
        rdbk(CRD, 16'h0005);
        op(ADV, '0, '0, 2);
        rdbk(CRD, 16'h0007);
        axr({20'h0, mpsb_pkg::OFF_CNT}, 32'h7, mpsb_pkg::RESP_OKAY);
        op(LD, 16'h1231, '0, 1);
        op(MK, 16'h0003, '0, 1);
        rdbk(MRD, 16'h0003);
        w0 = wrap_lows;
        op(ADV, '0, '0, 3);
        op('0, '0, '0, 3);
        chk(wrap_lows - w0, 32'h1);
        rdbk(CRD, 16'h1230);
        op(CRD, '0, '0, 4);
        master_reset_n <= 1'b0;
        #1 chk(addr_oe_n, 32'h1);
        @(posedge aclk);
        master_reset_n <= 1'b1;
        rdbk(CRD, 16'h0000);
        rdbk(MRD, 16'hFFFF);
        $display("counter test done");
        op(MK | LD, 16'h00F0, '0, 1);
        rdbk(CRD, 16'h0000);
        rdbk(MRD, 16'h00F0);
        op(LD, 16'h0042, '0, 1);
        op(CLR | MK | LD | ADV, 16'h0055, '0, 1);
        rdbk(CRD | MRD, 16'h0000);
        rdbk(MRD, 16'h00F0);
        $display("priority test done");
        op(SEL | LB | UB | WR, 16'h0100, 18'h2AB55, 1);
        op(SEL | LB | WR, 16'h0100, 18'h00123, 1);
        op(LB | UB | WR, 16'h0100, 18'h3FFFF, 1);
        op(SEL | LB | UB | OE, 16'h0100, '0, 4);
        chk(data_o, {9'h155, 9'h123});
        chk(data_oe_n, 32'h0);
        op(SEL | LB | UB, 16'h0100, '0, 0);
        #1 chk(data_oe_n, 32'h3);
        @(posedge aclk);
        op(SEL | UB | OE, 16'h0100, '0, 4);
        chk(data_oe_n, 32'h1);
        $display("byte lane test done");
        axr({20'h0, mpsb_pkg::OFF_VER}, mpsb_pkg::VER_VAL,
            mpsb_pkg::RESP_OKAY);
        axr(32'h40, '0, mpsb_pkg::RESP_SLVERR);
        axw(32'h40, '0, mpsb_pkg::RESP_SLVERR);
        axw({20'h0, mpsb_pkg::OFF_CTRL}, '0, mpsb_pkg::RESP_OKAY);
        $display("bus test done");
        wrap_up;
    end
endmodule
